// ### adc_ctrl_pkg.sv
// constants for the converter control and result queue block
package adc_ctrl_pkg;
   localparam int ADDR_W = 8;
   localparam int RESULT_W_DEF = 10;
   localparam int QUEUE_DEPTH = 4;
   localparam int QPTR_W = 2;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ZERO = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CONTROL_ONE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_GROUP_SELECT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

   // control zero fields
   localparam int C0_LOOP_BIT = 5;
   localparam int C0_SEQ_LSB = 2;
   localparam int C0_GO_BIT = 1;
   localparam int C0_ON_BIT = 0;

   // control one fields
   localparam int C1_REF_LSB = 6;
   localparam int C1_UNUSED_BIT = 5;
   localparam int C1_QEN_BIT = 4;
   localparam int C1_EMPTY_BIT = 3;
   localparam int C1_OVF_BIT = 2;
   localparam int C1_PTR_LSB = 0;

   // interrupt status fields
   localparam int IRQ_W = 2;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVF_BIT = 1;

   // reset values
   localparam logic [7:0] CONTROL_ZERO_RST = 8'h00;
   localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
   localparam logic [7:0] GROUP_SELECT_RST = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

   // sequence select encodings
   localparam logic [1:0] SEQ_GROUP_A = 2'h0;
   localparam logic [1:0] SEQ_GROUP_B = 2'h1;
   localparam logic [1:0] SEQ_GROUP_C = 2'h2;

   // reference select encodings
   localparam logic [1:0] REF_INTERNAL = 2'h0;
   localparam logic [1:0] REF_POS_EXT = 2'h1;
   localparam logic [1:0] REF_NEG_EXT = 2'h2;
   localparam logic [1:0] REF_BOTH_EXT = 2'h3;

   // group codes driven to the analog core
   localparam logic [1:0] GROUP_A = 2'h0;
   localparam logic [1:0] GROUP_B = 2'h1;
   localparam logic [1:0] GROUP_C = 2'h2;
endpackage : adc_ctrl_pkg

// ### result_queue.sv
// four-location result queue with per-location unread flags
`timescale 1ns/1ps
module result_queue #(
   parameter int WIDTH = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head_data,
   output logic [adc_ctrl_pkg::QPTR_W-1:0] read_ptr,
   output logic empty,
   output logic overwrite
);
   logic [WIDTH-1:0] store_reg [adc_ctrl_pkg::QUEUE_DEPTH];
   logic [adc_ctrl_pkg::QUEUE_DEPTH-1:0] unread_reg;
   logic [adc_ctrl_pkg::QPTR_W-1:0] wr_ptr_reg;
   logic [adc_ctrl_pkg::QPTR_W-1:0] rd_ptr_reg;
   logic do_pop;

   if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
      $error("result width must be 1..32");
   end

   assign empty = (unread_reg == '0);
   assign do_pop = pop && !empty;
   assign head_data = store_reg[rd_ptr_reg];
   assign read_ptr = rd_ptr_reg;
   assign overwrite = push && unread_reg[wr_ptr_reg];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= '0;
      end else if (flush) begin
         wr_ptr_reg <= '0;
      end else if (push) begin
         wr_ptr_reg <= wr_ptr_reg + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_ptr_reg <= '0;
      end else if (flush) begin
         rd_ptr_reg <= '0;
      end else if (do_pop) begin
         rd_ptr_reg <= rd_ptr_reg + 2'h1;
      end
   end

   always_ff @(posedge pclk) begin
      if (push) begin
         store_reg[wr_ptr_reg] <= push_data;
      end
   end

   // a push to the location being popped keeps it unread
   genvar i;
   generate
      for (i = 0; i < adc_ctrl_pkg::QUEUE_DEPTH; i++) begin : g_loc
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               unread_reg[i] <= 1'b0;
            end else if (flush) begin
               unread_reg[i] <= 1'b0;
            end else if (push && wr_ptr_reg == i) begin
               unread_reg[i] <= 1'b1;
            end else if (do_pop && rd_ptr_reg == i) begin
               unread_reg[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule : result_queue

// ### conversion_sequencer.sv
// runs one conversion at a time against the analog core
`timescale 1ns/1ps
module conversion_sequencer #(
   parameter int WIDTH = 10
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic go,
   input wire logic [1:0] seq_select,
   output logic core_start,
   output logic [1:0] core_group,
   input wire logic core_done,
   input wire logic [WIDTH-1:0] core_result,
   output logic result_valid,
   output logic [WIDTH-1:0] result_data,
   output logic busy
);
   typedef enum logic [1:0] {IDLE, START, WAIT} seq_state_e;
   seq_state_e state_reg;

   // the result cycle blocks a restart before go is cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= IDLE;
      end else if (!enable) begin
         state_reg <= IDLE;
      end else begin
         unique case (state_reg)
            IDLE: if (go && !result_valid) state_reg <= START;
            START: state_reg <= WAIT;
            WAIT: if (core_done) state_reg <= IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_group <= adc_ctrl_pkg::GROUP_A;
      end else if (state_reg == IDLE && go && !result_valid) begin
         unique case (seq_select)
            adc_ctrl_pkg::SEQ_GROUP_B: core_group <= adc_ctrl_pkg::GROUP_B;
            adc_ctrl_pkg::SEQ_GROUP_C: core_group <= adc_ctrl_pkg::GROUP_C;
            default: core_group <= adc_ctrl_pkg::GROUP_A;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_valid <= 1'b0;
         result_data <= '0;
      end else begin
         result_valid <= enable && state_reg == WAIT && core_done;
         if (enable && state_reg == WAIT && core_done) begin
            result_data <= core_result;
         end
      end
   end

   assign core_start = (state_reg == START) && enable;
   assign busy = (state_reg != IDLE);
endmodule : conversion_sequencer

// ### adc_control.sv
// converter control and status registers with result queue, APB slave
//
// Notes on behaviour
// - Sequence select 00, 01, 10 converts only channel group A, B, C.
// - Reference select picks internal rails or external positive/negative references.
// - Reference pins not claimed stay free as analog input or digital I/O.
// - Queue enable set routes results into the queue; cleared bypasses it.
// - Empty flag reads one when the queue holds no unread result.
// - Queue has four locations; empty reads zero while any holds unread data.
// - Overflow flag sets when a result overwrites an unread location.
// - Read pointer shows the location returned by the next result read.
// - Bit five of control register one reads zero, writes ignored.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module adc_control #(
   parameter int RESULT_W = adc_ctrl_pkg::RESULT_W_DEF
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic core_power_on,
   output logic core_start,
   output logic [1:0] core_group,
   output logic [7:0] core_group_select,
   input wire logic core_done,
   input wire logic [RESULT_W-1:0] core_result,
   output logic ref_pos_external,
   output logic ref_neg_external,
   output logic analog_input_two_free,
   output logic analog_input_three_free,
   output logic irq
);
   if (RESULT_W < 1 || RESULT_W > 32) begin : g_bad_width
      $error("RESULT_W must be 1..32");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register state

   logic module_on_bit;
   logic conv_go_reg;
   logic continuous_loop_select;
   logic [1:0] sequence_select_field;
   logic [1:0] reference_select_field;
   logic result_queue_enable;
   logic queue_overflow_flag;
   logic [7:0] channel_group_select_reg;
   logic [RESULT_W-1:0] bypass_result_reg;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_status_reg;
   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_mask_reg;

   logic queue_empty_flag;
   logic [1:0] queue_read_pointer;
   logic [RESULT_W-1:0] queue_head;
   logic queue_overwrite;
   logic result_valid;
   logic [RESULT_W-1:0] result_data;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic access;
   logic wr_en;
   logic rd_en;
   logic low_lane;
   logic addr_hit;
   logic wr_c0;
   logic wr_c1;
   logic wr_gs;
   logic wr_ist;
   logic wr_imask;
   logic rd_result;
   logic hit_c0;
   logic hit_c1;
   logic hit_gs;
   logic hit_res;
   logic hit_ist;
   logic hit_ims;

   assign access = psel && penable;
   assign wr_en = access && pwrite;
   assign rd_en = access && !pwrite;
   assign low_lane = pstrb[0];
   assign hit_c0 = paddr == adc_ctrl_pkg::OFS_CONTROL_ZERO;
   assign hit_c1 = paddr == adc_ctrl_pkg::OFS_CONTROL_ONE;
   assign hit_gs = paddr == adc_ctrl_pkg::OFS_GROUP_SELECT;
   assign hit_res = paddr == adc_ctrl_pkg::OFS_RESULT;
   assign hit_ist = paddr == adc_ctrl_pkg::OFS_IRQ_STATUS;
   assign hit_ims = paddr == adc_ctrl_pkg::OFS_IRQ_MASK;
   assign addr_hit = hit_c0 || hit_c1 || hit_gs || hit_res || hit_ist || hit_ims;
   assign wr_c0 = wr_en && low_lane && hit_c0;
   assign wr_c1 = wr_en && low_lane && hit_c1;
   assign wr_gs = wr_en && low_lane && hit_gs;
   assign wr_ist = wr_en && low_lane && hit_ist;
   assign wr_imask = wr_en && low_lane && hit_ims;
   assign rd_result = rd_en && hit_res;

   // zero-wait slave; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access && !addr_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // control register zero

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_on_bit <= adc_ctrl_pkg::CONTROL_ZERO_RST[adc_ctrl_pkg::C0_ON_BIT];
      end else if (wr_c0) begin
         module_on_bit <= pwdata[adc_ctrl_pkg::C0_ON_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         continuous_loop_select <= adc_ctrl_pkg::CONTROL_ZERO_RST[adc_ctrl_pkg::C0_LOOP_BIT];
         sequence_select_field <= adc_ctrl_pkg::CONTROL_ZERO_RST[adc_ctrl_pkg::C0_SEQ_LSB +: 2];
      end else if (wr_c0) begin
         continuous_loop_select <= pwdata[adc_ctrl_pkg::C0_LOOP_BIT];
         sequence_select_field <= pwdata[adc_ctrl_pkg::C0_SEQ_LSB +: 2];
      end
   end

   // software set wins over the completion clear
   logic go_write_set;
   logic go_hw_clear;
   assign go_write_set = wr_c0 && pwdata[adc_ctrl_pkg::C0_GO_BIT] &&
                         pwdata[adc_ctrl_pkg::C0_ON_BIT];
   assign go_hw_clear = result_valid && !continuous_loop_select;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_go_reg <= adc_ctrl_pkg::CONTROL_ZERO_RST[adc_ctrl_pkg::C0_GO_BIT];
      end else if (go_write_set) begin
         conv_go_reg <= 1'b1;
      end else if (wr_c0) begin
         conv_go_reg <= 1'b0;
      end else if (!module_on_bit) begin
         conv_go_reg <= 1'b0;
      end else if (go_hw_clear) begin
         conv_go_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // control register one, group select

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reference_select_field <= adc_ctrl_pkg::CONTROL_ONE_RST[adc_ctrl_pkg::C1_REF_LSB +: 2];
      end else if (wr_c1) begin
         reference_select_field <= pwdata[adc_ctrl_pkg::C1_REF_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_queue_enable <= adc_ctrl_pkg::CONTROL_ONE_RST[adc_ctrl_pkg::C1_QEN_BIT];
      end else if (wr_c1) begin
         result_queue_enable <= pwdata[adc_ctrl_pkg::C1_QEN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_group_select_reg <= adc_ctrl_pkg::GROUP_SELECT_RST;
      end else if (wr_gs) begin
         channel_group_select_reg <= pwdata[7:0];
      end
   end

   // reference routing and pin release
   always_comb begin
      unique case (reference_select_field)
         adc_ctrl_pkg::REF_INTERNAL: begin
            ref_pos_external = 1'b0;
            ref_neg_external = 1'b0;
         end
         adc_ctrl_pkg::REF_POS_EXT: begin
            ref_pos_external = 1'b1;
            ref_neg_external = 1'b0;
         end
         adc_ctrl_pkg::REF_NEG_EXT: begin
            ref_pos_external = 1'b0;
            ref_neg_external = 1'b1;
         end
         adc_ctrl_pkg::REF_BOTH_EXT: begin
            ref_pos_external = 1'b1;
            ref_neg_external = 1'b1;
         end
      endcase
   end

   // input two carries the negative reference, input three the positive one
   assign analog_input_two_free = !ref_neg_external;
   assign analog_input_three_free = !ref_pos_external;

   ////////////////////////////////////////////////////////////////////////////////
   // conversion path

   assign core_power_on = module_on_bit;
   assign core_group_select = channel_group_select_reg;

   // the sequencer idles whenever the module is off
   conversion_sequencer #(
      .WIDTH(RESULT_W)
   ) u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .enable(module_on_bit),
      .go(conv_go_reg),
      .seq_select(sequence_select_field),
      .core_start(core_start),
      .core_group(core_group),
      .core_done(core_done),
      .core_result(core_result),
      .result_valid(result_valid),
      .result_data(result_data),
      .busy()
   );

   // clearing the queue enable flushes every location
   result_queue #(
      .WIDTH(RESULT_W)
   ) u_queue (
      .pclk(pclk),
      .presetn(presetn),
      .flush(!result_queue_enable),
      .push(result_valid && result_queue_enable),
      .push_data(result_data),
      .pop(rd_result && result_queue_enable),
      .head_data(queue_head),
      .read_ptr(queue_read_pointer),
      .empty(queue_empty_flag),
      .overwrite(queue_overwrite)
   );

   // bypass holds the latest result while the queue is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_result_reg <= '0;
      end else if (result_valid && !result_queue_enable) begin
         bypass_result_reg <= result_data;
      end
   end

   // overflow stays until the queue is switched off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         queue_overflow_flag <= 1'b0;
      end else if (queue_overwrite && result_queue_enable) begin
         queue_overflow_flag <= 1'b1;
      end else if (!result_queue_enable) begin
         queue_overflow_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts

   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_events;
   assign irq_events[adc_ctrl_pkg::IRQ_DONE_BIT] = result_valid;
   assign irq_events[adc_ctrl_pkg::IRQ_OVF_BIT] = queue_overwrite && result_queue_enable;

   logic [adc_ctrl_pkg::IRQ_W-1:0] irq_clear;
   assign irq_clear = wr_ist ? pwdata[adc_ctrl_pkg::IRQ_W-1:0] : '0;

   // a hardware set wins over a same-cycle clear
   genvar b;
   generate
      for (b = 0; b < adc_ctrl_pkg::IRQ_W; b++) begin : g_irq
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_status_reg[b] <= adc_ctrl_pkg::IRQ_RST[b];
            end else if (irq_events[b]) begin
               irq_status_reg[b] <= 1'b1;
            end else if (irq_clear[b]) begin
               irq_status_reg[b] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= adc_ctrl_pkg::IRQ_RST;
      end else if (wr_imask) begin
         irq_mask_reg <= pwdata[adc_ctrl_pkg::IRQ_W-1:0];
      end
   end

   // level output while any unmasked status bit is set
   assign irq = |(irq_status_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // read data

   logic [7:0] control_zero_view;
   logic [7:0] control_one_view;
   logic [RESULT_W-1:0] result_view;

   always_comb begin
      control_zero_view = 8'h00;
      control_zero_view[adc_ctrl_pkg::C0_LOOP_BIT] = continuous_loop_select;
      control_zero_view[adc_ctrl_pkg::C0_SEQ_LSB +: 2] = sequence_select_field;
      control_zero_view[adc_ctrl_pkg::C0_GO_BIT] = conv_go_reg;
      control_zero_view[adc_ctrl_pkg::C0_ON_BIT] = module_on_bit;
   end

   always_comb begin
      control_one_view = 8'h00;
      control_one_view[adc_ctrl_pkg::C1_REF_LSB +: 2] = reference_select_field;
      control_one_view[adc_ctrl_pkg::C1_UNUSED_BIT] = 1'b0;
      control_one_view[adc_ctrl_pkg::C1_QEN_BIT] = result_queue_enable;
      control_one_view[adc_ctrl_pkg::C1_EMPTY_BIT] = queue_empty_flag;
      control_one_view[adc_ctrl_pkg::C1_OVF_BIT] = queue_overflow_flag;
      control_one_view[adc_ctrl_pkg::C1_PTR_LSB +: 2] = queue_read_pointer;
   end

   // result reads come from the queue head or the bypass word
   assign result_view = result_queue_enable ? queue_head : bypass_result_reg;

   always_comb begin
      prdata = 32'h00000000;
      if (rd_en) begin
         unique case (paddr)
            adc_ctrl_pkg::OFS_CONTROL_ZERO: prdata[7:0] = control_zero_view;
            adc_ctrl_pkg::OFS_CONTROL_ONE: prdata[7:0] = control_one_view;
            adc_ctrl_pkg::OFS_GROUP_SELECT: prdata[7:0] = channel_group_select_reg;
            adc_ctrl_pkg::OFS_RESULT: prdata[RESULT_W-1:0] = result_view;
            adc_ctrl_pkg::OFS_IRQ_STATUS: prdata[adc_ctrl_pkg::IRQ_W-1:0] = irq_status_reg;
            adc_ctrl_pkg::OFS_IRQ_MASK: prdata[adc_ctrl_pkg::IRQ_W-1:0] = irq_mask_reg;
            default: prdata = 32'h00000000;
         endcase
      end
   end
endmodule : adc_control

// ### adc_control_checker.sv
// port assertions for the converter control block
`timescale 1ns/1ps
module adc_control_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_ctrl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic core_power_on,
   input wire logic core_start,
   input wire logic [1:0] core_group,
   input wire logic ref_pos_external,
   input wire logic ref_neg_external,
   input wire logic analog_input_two_free,
   input wire logic analog_input_three_free
);
   wire logic acc = psel && penable;
   wire logic wr_en = acc && pwrite && pstrb[0];
   wire logic wr0 = wr_en && paddr == adc_ctrl_pkg::OFS_CONTROL_ZERO;
   wire logic wr1 = wr_en && paddr == adc_ctrl_pkg::OFS_CONTROL_ONE;
   wire logic rd1 = acc && !pwrite && paddr == adc_ctrl_pkg::OFS_CONTROL_ONE;
   wire logic mapped = paddr <= adc_ctrl_pkg::OFS_IRQ_MASK && paddr[1:0] == 2'h0;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   a_power_follows: assert property (wr0 |=> core_power_on == $past(pwdata[0]))
      else $error("module on does not follow write");
   a_start_powered: assert property (core_start |-> core_power_on)
      else $error("start while powered down");
   a_go_when_off: assert property (wr0 && pwdata[1:0] == 2'h2 |=> !core_start [*3])
      else $error("start taken while module off");
   a_group_follows: assert property (wr0 && !core_power_on && pwdata[1:0] == 2'h3 &&
      pwdata[3:2] != 2'h3 |-> ##2 core_start && core_group == $past(pwdata[3:2], 2))
      else $error("wrong group started");
   a_pos_ref_select: assert property (wr1 |=> ref_pos_external == $past(pwdata[6]))
      else $error("positive reference decode wrong");
   a_neg_ref_select: assert property (wr1 |=> ref_neg_external == $past(pwdata[7]))
      else $error("negative reference decode wrong");
   a_two_pin_free: assert property (analog_input_two_free != ref_neg_external)
      else $error("input two claim wrong");
   a_three_pin_free: assert property (analog_input_three_free != ref_pos_external)
      else $error("input three claim wrong");
   a_spare_bit_zero: assert property (rd1 |-> prdata[5] == 1'b0)
      else $error("spare bit reads one");
   a_unmapped_error: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");

   c_start: cover property (core_start);
   c_ref_both: cover property (ref_pos_external && ref_neg_external);
   c_unmapped: cover property (acc && !mapped);
endmodule : adc_control_checker

bind adc_control adc_control_checker adc_control_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
   .core_power_on(core_power_on), .core_start(core_start), .core_group(core_group),
   .ref_pos_external(ref_pos_external), .ref_neg_external(ref_neg_external),
   .analog_input_two_free(analog_input_two_free),
   .analog_input_three_free(analog_input_three_free)
);

// ### adc_control_fifo_status_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_control_fifo_status_bench;
   localparam logic [7:0] C0 = adc_ctrl_pkg::OFS_CONTROL_ZERO;
   localparam logic [7:0] C1 = adc_ctrl_pkg::OFS_CONTROL_ONE;
   localparam logic [7:0] GS = adc_ctrl_pkg::OFS_GROUP_SELECT;
   localparam logic [7:0] RES = adc_ctrl_pkg::OFS_RESULT;
   localparam logic [7:0] IST = adc_ctrl_pkg::OFS_IRQ_STATUS;
   localparam logic [7:0] IMS = adc_ctrl_pkg::OFS_IRQ_MASK;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready, pslverr, core_power_on, core_start, irq, core_done = 1'b0;
   logic [1:0] core_group;
   logic [7:0] core_group_select;
   logic [9:0] core_result = 10'h000;
   logic ref_pos_external, ref_neg_external, analog_input_two_free, analog_input_three_free;
   logic [31:0] drain [4] = '{32'h205, 32'h202, 32'h203, 32'h204};
   int err_count = 0;
   int checked = 0;
   int starts = 0;
   int served = 0;

   always #25 pclk = ~pclk;
   always @(posedge pclk) if (core_start === 1'b1) starts++;

   adc_control adc_control_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_power_on(core_power_on),
      .core_start(core_start), .core_group(core_group), .core_group_select(core_group_select),
      .core_done(core_done), .core_result(core_result), .ref_pos_external(ref_pos_external),
      .ref_neg_external(ref_neg_external), .analog_input_two_free(analog_input_two_free),
      .analog_input_three_free(analog_input_three_free), .irq(irq));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask : wr

   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      xfer(1'b0, a, 32'h0, q, e);
      check(what, q, exp);
      check("slverr low", 32'(e), 32'h0);
   endtask : rdc

   // answers the next start with one done pulse
   task automatic conv(input logic [9:0] r, input logic [1:0] g);
      while (starts == served) @(posedge pclk);
      served++;
      check("group", 32'(core_group), 32'(g));
      core_done <= 1'b1;
      core_result <= r;
      @(posedge pclk);
      core_done <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : conv

   task automatic shot(input logic [9:0] r);
      wr(C0, 32'h3);
      conv(r, 2'h0);
   endtask : shot

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic e;
      int n;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rdc("ctl0 reset", C0, 32'h00);
      rdc("ctl1 reset", C1, 32'h08);
      for (int i = 0; i < 4; i++) begin
         wr(C1, 32'(i << 6) | 32'h20);
         rdc("ref sel", C1, 32'(i << 6) | 32'h08);
         check("ref pos", 32'(ref_pos_external), 32'(i & 1));
         check("ref neg", 32'(ref_neg_external), 32'(i >> 1));
         check("two free", 32'(analog_input_two_free), 32'(1 - (i >> 1)));
         check("three free", 32'(analog_input_three_free), 32'(1 - (i & 1)));
      end
      wr(GS, 32'hA5);
      rdc("gsel", GS, 32'hA5);
      check("gsel out", 32'(core_group_select), 32'hA5);
      n = starts;
      wr(C0, 32'h02);
      rdc("go while off", C0, 32'h00);
      check("no start", 32'(starts), 32'(n));
      xfer(1'b0, 8'h18, 32'h0, q, e);
      check("slverr", 32'(e), 32'h1);
      check("unmapped data", q, 32'h0);
      wr(IMS, 32'h1);
      for (int g = 0; g < 3; g++) begin
         wr(C0, 32'h00);
         wr(C0, 32'(g << 2) | 32'h3);
         conv(10'h100 + 10'(g), 2'(g));
         rdc("go clear", C0, 32'(g << 2) | 32'h1);
         rdc("bypass", RES, 32'h100 + 32'(g));
         check("irq on", 32'(irq), 32'h1);
         wr(IST, 32'h1);
         rdc("status", IST, 32'h0);
         check("irq off", 32'(irq), 32'h0);
      end
      wr(IMS, 32'h0);
      wr(C1, 32'h10);
      rdc("queue on", C1, 32'h18);
      for (int k = 0; k < 4; k++) shot(10'h200 + 10'(k));
      rdc("four held", C1, 32'h10);
      rdc("head", RES, 32'h200);
      rdc("ptr step", C1, 32'h11);
      shot(10'h204);
      rdc("no overwrite", C1, 32'h11);
      shot(10'h205);
      rdc("overwrite", C1, 32'h15);
      rdc("status both", IST, 32'h3);
      check("irq masked", 32'(irq), 32'h0);
      wr(IMS, 32'h2);
      rdc("mask", IMS, 32'h2);
      check("irq unmasked", 32'(irq), 32'h1);
      wr(IST, 32'h3);
      rdc("status clear", IST, 32'h0);
      check("irq clear", 32'(irq), 32'h0);
      for (int k = 0; k < 4; k++) rdc("drain", RES, drain[k]);
      rdc("drained", C1, 32'h1D);
      xfer(1'b0, RES, 32'h0, q, e);
      rdc("pop empty", C1, 32'h1D);
      wr(C1, 32'h00);
      rdc("bypass again", C1, 32'h08);
      wr(C0, 32'h23);
      conv(10'h300, 2'h0);
      rdc("loop go", C0, 32'h23);
      wr(C0, 32'h21);
      conv(10'h301, 2'h0);
      n = starts;
      repeat (10) @(posedge pclk);
      check("loop stop", 32'(starts), 32'(n));
      rdc("loop go off", C0, 32'h21);
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      end_of_test();
   end
endmodule : adc_control_fifo_status_bench
